//--- verilog/hbcs_ctrl.sv
// Control logic of a brushed DC motor H-bridge: decode, chopping, faults and sleep.
`timescale 1ns/100ps
module hbcs_ctrl
  import hbcs_pkg::*;
#(
  parameter int unsigned SLEEP_LEN = SLEEP_CYC,
  parameter int unsigned WAKE_LEN = WAKE_CYC,
  parameter int unsigned RETRY_LEN = RETRY_CYC,
  parameter int unsigned OFF_LEN = OFF_TIME_CYC,
  parameter int unsigned BLANK_LEN = BLANK_CYC,
  parameter int unsigned TRIP_DEG_LEN = TRIP_DEG_CYC,
  parameter int unsigned OC_DEG_LEN = OC_DEG_CYC,
  parameter int unsigned DEAD_LEN = DEAD_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic direction_input_a,
  input wire logic direction_input_b,
  input wire logic trip_compare,
  input wire logic [NUM_SW-1:0] switch_current_limit,
  input wire logic thermal_shutdown,
  input wire logic supply_low_lockout,
  output hbcs_leg_t bridge_output_a,
  output hbcs_leg_t bridge_output_b,
  output hbcs_mode_t device_mode,
  output logic chopping
);

  // Interval end points at counter width.
  localparam logic [CNT_W-1:0] SLEEP_LAST = CNT_W'(SLEEP_LEN - 1);
  localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_LEN - 1);
  localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_LEN - 1);
  localparam logic [CNT_W-1:0] OFF_N = CNT_W'(OFF_LEN);
  localparam logic [CNT_W-1:0] BLANK_N = CNT_W'(BLANK_LEN);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  typedef struct packed {
    hbcs_dir_t dir_s1;
    hbcs_dir_t dir_s2;
    logic trip_s1;
    logic trip_s2;
    logic [NUM_SW-1:0] oc_s1;
    logic [NUM_SW-1:0] oc_s2;
    logic hot_s1;
    logic hot_s2;
    hbcs_mode_t mode;
    logic chop;
    hbcs_dir_t dir_at;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] offt;
    logic [CNT_W-1:0] blank;
    hbcs_leg_cmd_t cmd_a;
    hbcs_leg_cmd_t cmd_b;
  } hbcs_ctrl_state_t;

  hbcs_ctrl_state_t q;
  hbcs_ctrl_state_t d;
  logic uv_s1_q;
  logic uv_s2_q;
  logic logic_rst;
  logic trip_din;
  logic trip_hit;
  logic [NUM_SW-1:0] oc_din;
  logic [NUM_SW-1:0] oc_hits;
  logic oc_hit;
  logic any_high;
  hbcs_leg_cmd_t want_a;
  hbcs_leg_cmd_t want_b;

  // The lockout synchroniser runs on the system reset only; resetting it from the lockout
  // itself would reload it with ones, so the lockout would never release and the logic would stay in reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uv_s1_q <= 1'b1;
      uv_s2_q <= 1'b1;
    end else begin
      uv_s1_q <= supply_low_lockout;
      uv_s2_q <= uv_s1_q;
    end
  end

  // Undervoltage holds all logic except the lockout synchroniser in reset, and the bridge off.
  assign logic_rst = sys_rst || uv_s2_q;

  // The trip detector only sees the comparator outside blanking and outside an off-time.
  assign trip_din = q.trip_s2 && (q.blank == '0) && (q.mode == MODE_ACTIVE) && !q.chop;
  assign any_high = q.dir_s2.a || q.dir_s2.b;

  hbcs_deglitch #(
    .LEN(TRIP_DEG_LEN),
    .CW(CNT_W)
  ) u_trip_deg (
    .clk(clk),
    .sys_rst(logic_rst),
    .din(trip_din),
    .hit(trip_hit)
  );

  // One persistence filter per switch, so a short on any leg is caught on its own.
  for (genvar i = 0; i < NUM_SW; i++) begin : g_oc
    assign oc_din[i] = q.oc_s2[i] && (q.mode == MODE_ACTIVE);
    hbcs_deglitch #(
      .LEN(OC_DEG_LEN),
      .CW(CNT_W)
    ) u_oc_deg (
      .clk(clk),
      .sys_rst(logic_rst),
      .din(oc_din[i]),
      .hit(oc_hits[i])
    );
  end

  assign oc_hit = |oc_hits;

  // Input decode; chopping overrides with brake, any other mode leaves the bridge open.
  always_comb begin
    case ({q.dir_s2.a, q.dir_s2.b})
      2'b01: begin
        want_a = LEG_LOW;
        want_b = LEG_HIGH;
      end
      2'b10: begin
        want_a = LEG_HIGH;
        want_b = LEG_LOW;
      end
      2'b11: begin
        want_a = LEG_LOW;
        want_b = LEG_LOW;
      end
      default: begin
        want_a = LEG_OFF;
        want_b = LEG_OFF;
      end
    endcase
    if (q.mode != MODE_ACTIVE) begin
      want_a = LEG_OFF;
      want_b = LEG_OFF;
    end else if (q.chop) begin
      want_a = LEG_LOW;
      want_b = LEG_LOW;
    end
  end

  // Next state: synchronisers, mode sequencing, chopping and blanking.
  always_comb begin
    d = q;
    d.dir_s1 = hbcs_dir_t'({direction_input_a, direction_input_b});
    d.dir_s2 = q.dir_s1;
    d.trip_s1 = trip_compare;
    d.trip_s2 = q.trip_s1;
    d.oc_s1 = switch_current_limit;
    d.oc_s2 = q.oc_s1;
    d.hot_s1 = thermal_shutdown;
    d.hot_s2 = q.hot_s1;
    d.cmd_a = want_a;
    d.cmd_b = want_b;
    // Every change of the commanded pattern restarts the blanking window.
    if ((want_a != q.cmd_a) || (want_b != q.cmd_b)) begin
      d.blank = BLANK_N;
    end else if (q.blank != '0) begin
      d.blank = q.blank - 1'b1;
    end
    // Fixed off-time chopping inside active mode.
    if (q.mode == MODE_ACTIVE) begin
      if (!q.chop) begin
        if (trip_hit) begin
          d.chop = 1'b1;
          d.offt = OFF_N;
          d.dir_at = q.dir_s2;
        end
      end else if (q.dir_s2 != q.dir_at) begin
        d.chop = 1'b0;
      end else if (q.offt == CNT_W'(1)) begin
        if (q.trip_s2) begin
          d.offt = OFF_N;
        end else begin
          d.chop = 1'b0;
        end
      end else begin
        d.offt = q.offt - 1'b1;
      end
    end
    // Mode sequencing; thermal outranks overcurrent, and both keep the logic running.
    case (q.mode)
      MODE_SLEEP: begin
        if (!any_high) begin
          d.tmr = '0;
        end else if (q.tmr == WAKE_LAST) begin
          d.mode = MODE_ACTIVE;
          d.tmr = '0;
        end else begin
          d.tmr = q.tmr + 1'b1;
        end
      end
      MODE_ACTIVE: begin
        if (q.hot_s2) begin
          d.mode = MODE_TSD_OFF;
          d.chop = 1'b0;
          d.tmr = '0;
        end else if (oc_hit) begin
          d.mode = MODE_OCP_OFF;
          d.chop = 1'b0;
          d.tmr = '0;
        end else if (any_high) begin
          d.tmr = '0;
        end else if (q.tmr == SLEEP_LAST) begin
          d.mode = MODE_SLEEP;
          d.chop = 1'b0;
          d.tmr = '0;
        end else if (q.tmr != CNT_MAX) begin
          d.tmr = q.tmr + 1'b1;
        end
      end
      MODE_OCP_OFF: begin
        if (q.hot_s2) begin
          d.mode = MODE_TSD_OFF;
          d.tmr = '0;
        end else if (q.tmr == RETRY_LAST) begin
          d.mode = MODE_ACTIVE;
          d.tmr = '0;
        end else begin
          d.tmr = q.tmr + 1'b1;
        end
      end
      MODE_TSD_OFF: begin
        if (!q.hot_s2) begin
          d.mode = MODE_ACTIVE;
          d.tmr = '0;
        end
      end
      default: begin
        d.mode = MODE_SLEEP;
        d.tmr = '0;
      end
    endcase
  end

  // State register; reset lands in sleep, so power-up with both inputs low sleeps at once.
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      q <= '{dir_s1: DIR_RESET, dir_s2: DIR_RESET, trip_s1: 1'b0, trip_s2: 1'b0, oc_s1: '0,
             oc_s2: '0, hot_s1: 1'b0, hot_s2: 1'b0, mode: MODE_RESET, chop: 1'b0,
             dir_at: DIR_RESET, tmr: '0, offt: '0, blank: '0, cmd_a: LEG_OFF,
             cmd_b: LEG_OFF};
    end else begin
      q <= d;
    end
  end

  hbcs_half_bridge #(
    .DEAD(DEAD_LEN),
    .CW(CNT_W)
  ) u_leg_a (
    .clk(clk),
    .sys_rst(logic_rst),
    .cmd(q.cmd_a),
    .drive(bridge_output_a)
  );

  hbcs_half_bridge #(
    .DEAD(DEAD_LEN),
    .CW(CNT_W)
  ) u_leg_b (
    .clk(clk),
    .sys_rst(logic_rst),
    .cmd(q.cmd_b),
    .drive(bridge_output_b)
  );

  assign device_mode = q.mode;
  assign chopping = q.chop;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (logic_rst);

  sequence s_off_end_low;
    q.mode == MODE_ACTIVE && q.chop && q.dir_s2 == q.dir_at && q.offt == CNT_W'(1) && !q.trip_s2;
  endsequence

  // A thermal, overcurrent or sleep transition at the same edge outranks the reload of the off-time.
  sequence s_off_end_high;
    q.mode == MODE_ACTIVE && q.chop && q.dir_s2 == q.dir_at && q.offt == CNT_W'(1) && q.trip_s2
      && !q.hot_s2 && !oc_hit && (any_high || q.tmr != SLEEP_LAST);
  endsequence

  sequence s_wake_step;
    q.mode == MODE_SLEEP ##1 q.mode == MODE_ACTIVE;
  endsequence

  AST_FWD_DECODE: assert property ((q.mode == MODE_ACTIVE && !q.chop && q.dir_s2 == 2'b10)
    |=> q.cmd_a == LEG_HIGH && q.cmd_b == LEG_LOW)
    else $error("Forward input did not command forward drive.");

  AST_CHOP_BRAKE: assert property ((q.mode == MODE_ACTIVE && q.chop)
    |=> q.cmd_a == LEG_LOW && q.cmd_b == LEG_LOW)
    else $error("Off-time without low-side brake.");

  AST_CHOP_START: assert property ($rose(q.chop) |-> q.offt == OFF_N && $past(trip_hit))
    else $error("Off-time began without a deglitched trip.");

  AST_OFF_RELEASE: assert property (s_off_end_low |=> !q.chop)
    else $error("Off-time not released with current below trip.");

  AST_OFF_AGAIN: assert property (s_off_end_high |=> q.chop && q.offt == OFF_N)
    else $error("Off-time not restarted with current above trip.");

  AST_INPUT_ABORT: assert property ((q.mode == MODE_ACTIVE && q.chop && q.dir_s2 != q.dir_at)
    |=> !q.chop)
    else $error("Input change did not end the off-time.");

  AST_BLANK_MASK: assert property ($rose(q.chop) |-> $past(q.blank, 2) == '0)
    else $error("Off-time began from a trip seen during blanking.");

  AST_OC_SHUTDOWN: assert property ((q.mode == MODE_ACTIVE && oc_hit && !q.hot_s2)
    |=> q.mode == MODE_OCP_OFF ##1 q.cmd_a == LEG_OFF && q.cmd_b == LEG_OFF)
    else $error("Overcurrent did not open the bridge.");

  AST_OC_RETRY: assert property ((q.mode == MODE_OCP_OFF && q.tmr == RETRY_LAST && !q.hot_s2)
    |=> q.mode == MODE_ACTIVE)
    else $error("Bridge not re-enabled after the retry period.");

  AST_TSD_RESUME: assert property ((q.mode == MODE_TSD_OFF && !q.hot_s2) |=> q.mode == MODE_ACTIVE)
    else $error("No resume after thermal indication cleared.");

  AST_FAULT_OPEN: assert property ((q.mode != MODE_ACTIVE) |=> q.cmd_a == LEG_OFF && q.cmd_b == LEG_OFF)
    else $error("Bridge commanded while not active.");

  AST_SLEEP_ENTRY: assert property ((q.mode == MODE_ACTIVE && !any_high && q.tmr == SLEEP_LAST
    && !q.hot_s2 && !oc_hit) |=> q.mode == MODE_SLEEP)
    else $error("Sleep not entered after the sleep interval.");

  AST_WAKE_TIME: assert property (s_wake_step |-> $past(q.tmr) == WAKE_LAST && $past(any_high))
    else $error("Woke before the wake interval elapsed.");

endmodule : hbcs_ctrl

//--- verilog/hbcs_pkg.sv
// Shared constants, timing figures and carrier types of the H-bridge chop and fault controller.
package hbcs_pkg;

  // Clock period of the single logic clock.
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Counter width large enough for the longest interval (retry).
  localparam int CNT_W = 20;

  // Number of bridge switches, each with its own current-limit detector.
  localparam int NUM_SW = 4;

  // Interval lengths in nanoseconds; all are plain defaults.
  localparam int unsigned OFF_TIME_NS = 20000;
  localparam int unsigned BLANK_NS = 1800;
  localparam int unsigned TRIP_DEG_NS = 1000;
  localparam int unsigned OC_DEG_NS = 3000;
  localparam int unsigned DEAD_NS = 200;
  localparam int unsigned SLEEP_NS = 1000000;
  localparam int unsigned WAKE_NS = 250000;
  localparam int unsigned RETRY_NS = 2000000;

  // Least times round up to whole clock cycles.
  localparam int unsigned OFF_TIME_CYC = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRIP_DEG_CYC = (TRIP_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OC_DEG_CYC = (OC_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_CYC = (SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RETRY_CYC = (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Operating modes of the device.
  typedef enum logic [3:0] {
    MODE_SLEEP = 4'h1,
    MODE_ACTIVE = 4'h2,
    MODE_OCP_OFF = 4'h4,
    MODE_TSD_OFF = 4'h8
  } hbcs_mode_t;

  // Command to one half-bridge leg.
  typedef enum logic [2:0] {
    LEG_OFF = 3'h1,
    LEG_HIGH = 3'h2,
    LEG_LOW = 3'h4
  } hbcs_leg_cmd_t;

  // Gate drive of one leg: high-side and low-side switch.
  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } hbcs_leg_t;

  // The two direction inputs as one pair.
  typedef struct packed {
    logic a;
    logic b;
  } hbcs_dir_t;

  // Reset values.
  localparam hbcs_leg_t LEG_RESET = 2'h0;
  localparam hbcs_dir_t DIR_RESET = 2'h0;
  localparam hbcs_mode_t MODE_RESET = MODE_SLEEP;

endpackage : hbcs_pkg

//--- verilog/hbcs_deglitch.sv
// Persistence filter: output rises once the input has been high for a set number of cycles.
`timescale 1ns/100ps
module hbcs_deglitch
  import hbcs_pkg::*;
#(
  parameter int unsigned LEN = 4,
  parameter int CW = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic din,
  output logic hit
);

  localparam logic [CW-1:0] LEN_N = CW'(LEN);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic hit;
  } hbcs_dg_state_t;

  hbcs_dg_state_t q;
  hbcs_dg_state_t d;

  // Any low sample restarts the count, so short pulses never reach the output.
  always_comb begin
    d = q;
    if (!din) begin
      d.cnt = '0;
      d.hit = 1'b0;
    end else begin
      if (q.cnt != LEN_N) begin
        d.cnt = q.cnt + 1'b1;
      end
      d.hit = (d.cnt == LEN_N);
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hit = q.hit;

  AST_DG_NEEDS_INPUT: assert property (@(posedge clk) disable iff (sys_rst)
    hit |-> $past(din) && q.cnt == LEN_N)
    else $error("Deglitch output high without held input.");

endmodule : hbcs_deglitch

//--- verilog/hbcs_half_bridge.sv
// One half-bridge leg with dead time between high-side and low-side drive.
`timescale 1ns/100ps
module hbcs_half_bridge
  import hbcs_pkg::*;
#(
  parameter int unsigned DEAD = 40,
  parameter int CW = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire hbcs_leg_cmd_t cmd,
  output hbcs_leg_t drive
);

  localparam logic [CW-1:0] DEAD_N = CW'(DEAD);

  typedef struct packed {
    hbcs_leg_t drive;
    logic [CW-1:0] cnt;
  } hbcs_hb_state_t;

  hbcs_hb_state_t q;
  hbcs_hb_state_t want;
  hbcs_hb_state_t d;

  // A leg that is on and asked for anything else goes high-impedance first and waits out the
  // dead time; turning on from rest after the wait is immediate.
  always_comb begin
    want = q;
    want.drive.hs_on = (cmd == LEG_HIGH);
    want.drive.ls_on = (cmd == LEG_LOW);
    d = q;
    if ((q.drive.hs_on || q.drive.ls_on) && (q.drive != want.drive)) begin
      d.drive = LEG_RESET;
      d.cnt = DEAD_N;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end else begin
      d.drive = want.drive;
    end
  end

  // State register; reset leaves both switches off.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '{drive: LEG_RESET, cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign drive = q.drive;

  AST_HB_NO_SHOOT: assert property (@(posedge clk) disable iff (sys_rst)
    !(q.drive.hs_on && q.drive.ls_on))
    else $error("Both switches of one leg are on.");

  AST_HB_DEAD_WAIT: assert property (@(posedge clk) disable iff (sys_rst)
    ($rose(q.drive.hs_on) || $rose(q.drive.ls_on)) |-> $past(q.cnt) == '0)
    else $error("Switch turned on before the dead time ran out.");

endmodule : hbcs_half_bridge

//--- verification/hbcs_mcu_model.sv
// Behavioural model of the external controller that drives the two direction pins.
`timescale 1ns/100ps
module hbcs_mcu_model
  import hbcs_pkg::*;
(
  input wire logic clk,
  input wire hbcs_dir_t want,
  output logic direction_input_a = 1'b0,
  output logic direction_input_b = 1'b0
);
  // Pins move on the falling edge only, so the device never samples a pin mid-change.
  // Levels stay static until a new command; that gives full-duty drive and long wake holds.
  always @(negedge clk) begin
    direction_input_a <= want.a;
    direction_input_b <= want.b;
  end
endmodule : hbcs_mcu_model

//--- verification/hbcs_ctrl_bench.sv
// Self-checking bench of the H-bridge controller, with the controller model on its direction pins.
`timescale 1ns/100ps
module hbcs_ctrl_bench;
  import hbcs_pkg::*;
  localparam int SLP = 20;
  localparam int WAK = 10;
  localparam int RTY = 30;
  localparam int OFF = 16;
  localparam int BLK = 8;
  localparam int TDG = 3;
  localparam int OCD = 3;
  localparam int DED = 2;
  localparam int LIMIT = 20000;
  // Expected {leg a, leg b} drive as {hs, ls, hs, ls}.
  localparam logic [3:0] FWD = 4'h9;
  localparam logic [3:0] REV = 4'h6;
  localparam logic [3:0] BRK = 4'h5;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic trip_compare = 1'b0;
  logic thermal_shutdown = 1'b0;
  logic supply_low_lockout = 1'b0;
  logic [NUM_SW-1:0] switch_current_limit = '0;
  hbcs_dir_t want = DIR_RESET;
  logic direction_input_a;
  logic direction_input_b;
  hbcs_leg_t bridge_output_a;
  hbcs_leg_t bridge_output_b;
  hbcs_mode_t device_mode;
  logic chopping;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  wire [3:0] legs = {bridge_output_a, bridge_output_b};

  // Clock of 5 ns period.
  always #2.5 clk = ~clk;

  hbcs_mcu_model mcu (.clk(clk), .want(want), .direction_input_a(direction_input_a),
    .direction_input_b(direction_input_b));

  // Short counts keep the run small; every expectation below is derived from them.
  hbcs_ctrl #(.SLEEP_LEN(SLP), .WAKE_LEN(WAK), .RETRY_LEN(RTY), .OFF_LEN(OFF), .BLANK_LEN(BLK),
    .TRIP_DEG_LEN(TDG), .OC_DEG_LEN(OCD), .DEAD_LEN(DED)) dut (
    .clk(clk), .sys_rst(sys_rst), .direction_input_a(direction_input_a),
    .direction_input_b(direction_input_b), .trip_compare(trip_compare),
    .switch_current_limit(switch_current_limit), .thermal_shutdown(thermal_shutdown),
    .supply_low_lockout(supply_low_lockout), .bridge_output_a(bridge_output_a),
    .bridge_output_b(bridge_output_b), .device_mode(device_mode), .chopping(chopping));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // A hung wait must not stall the run forever.
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic set_dir(input logic [1:0] d);
    @(negedge clk);
    want <= d;
  endtask : set_dir

  task automatic wait_mode(input hbcs_mode_t m, input int n);
    for (int i = 0; i < n && device_mode !== m; i++) @(negedge clk);
    check(device_mode, m, "mode");
  endtask : wait_mode

  task automatic wait_chop(input logic v, input int n);
    for (int i = 0; i < n && chopping !== v; i++) @(negedge clk);
    check(chopping, v, "chopping");
  endtask : wait_chop

  // Counts cycles with chopping high; any hit means a trip that should have been dropped.
  task automatic watch_chop(input int n, output int hits);
    hits = 0;
    repeat (n) begin
      @(negedge clk);
      if (chopping !== 1'b0) hits++;
    end
  endtask : watch_chop

  task automatic t_wake_decode();
    logic [1:0] dirs [3];
    logic [3:0] exps [3];
    dirs = '{2'b10, 2'b11, 2'b01};
    exps = '{FWD, BRK, REV};
    set_dir(2'b10);
    tick(WAK / 2);
    check(device_mode, MODE_SLEEP, "early wake");
    wait_mode(MODE_ACTIVE, WAK + 10);
    for (int i = 0; i < 3; i++) begin
      set_dir(dirs[i]);
      tick(14);
      check(legs, exps[i], "decode");
    end
  endtask : t_wake_decode

  task automatic t_dead();
    int bad;
    int off;
    bad = 0;
    off = 0;
    set_dir(2'b10);
    repeat (16) begin
      @(negedge clk);
      if (legs[3:2] === 2'b11 || legs[1:0] === 2'b11) bad++;
      if (legs[3:2] === 2'b00) off++;
    end
    check(bad, 0, "shoot-through");
    check(off >= DED + 1, 1, "dead time");
    check(legs, FWD, "forward");
  endtask : t_dead

  task automatic t_deglitch();
    int hits;
    tick(BLK + 4);
    trip_compare <= 1'b1;
    tick(TDG - 1);
    trip_compare <= 1'b0;
    watch_chop(12, hits);
    check(hits, 0, "short trip");
  endtask : t_deglitch

  task automatic t_chop();
    trip_compare <= 1'b1;
    wait_chop(1'b1, TDG + 8);
    tick(8);
    check(legs, BRK, "chop brake");
    tick(OFF);
    check(chopping, 1'b1, "second off-time");
    check(legs, BRK, "second brake");
    trip_compare <= 1'b0;
    wait_chop(1'b0, OFF + 8);
    tick(10);
    check(legs, FWD, "resume");
  endtask : t_chop

  task automatic t_abort();
    tick(BLK + 4);
    trip_compare <= 1'b1;
    wait_chop(1'b1, TDG + 8);
    trip_compare <= 1'b0;
    set_dir(2'b01);
    tick(7);
    check(chopping, 1'b0, "abort");
    tick(10);
    check(legs, REV, "follow");
  endtask : t_abort

  // The trip lasts long enough to pass the filter, but only while blanking is running.
  task automatic t_blank();
    int hits;
    set_dir(2'b11);
    tick(4);
    trip_compare <= 1'b1;
    tick(6);
    trip_compare <= 1'b0;
    watch_chop(14, hits);
    check(hits, 0, "blanked trip");
    set_dir(2'b10);
    tick(14);
  endtask : t_blank

  task automatic t_overcurrent();
    for (int i = 0; i < NUM_SW; i++) begin
      switch_current_limit <= NUM_SW'(1) << i;
      wait_mode(MODE_OCP_OFF, OCD + 8);
      tick(3);
      check(legs, 4'h0, "bridge off");
      tick(RTY - 8);
      check(device_mode, MODE_OCP_OFF, "early retry");
      wait_mode(MODE_ACTIVE, 16);
      wait_mode(MODE_OCP_OFF, OCD + 8);
      switch_current_limit <= '0;
      wait_mode(MODE_ACTIVE, RTY + 8);
      tick(14);
    end
  endtask : t_overcurrent

  task automatic t_thermal();
    thermal_shutdown <= 1'b1;
    wait_mode(MODE_TSD_OFF, 6);
    tick(3);
    check(legs, 4'h0, "thermal off");
    thermal_shutdown <= 1'b0;
    wait_mode(MODE_ACTIVE, 6);
    tick(14);
    check(legs, FWD, "thermal resume");
    // Heat during an overcurrent wait must take over and hold past the retry period.
    switch_current_limit <= NUM_SW'(1);
    wait_mode(MODE_OCP_OFF, OCD + 8);
    switch_current_limit <= '0;
    thermal_shutdown <= 1'b1;
    wait_mode(MODE_TSD_OFF, 6);
    tick(RTY + 4);
    check(device_mode, MODE_TSD_OFF, "thermal over retry");
    check(legs, 4'h0, "thermal over retry outputs");
    thermal_shutdown <= 1'b0;
    wait_mode(MODE_ACTIVE, 6);
    tick(14);
    check(legs, FWD, "resume after both faults");
  endtask : t_thermal

  task automatic t_lockout();
    supply_low_lockout <= 1'b1;
    tick(5);
    check(device_mode, MODE_SLEEP, "lockout mode");
    check({legs, chopping}, 5'h00, "lockout outputs");
    supply_low_lockout <= 1'b0;
    tick(WAK / 2);
    check(device_mode, MODE_SLEEP, "rewake hold");
    wait_mode(MODE_ACTIVE, WAK + 10);
  endtask : t_lockout

  task automatic t_sleep();
    set_dir(2'b00);
    tick(8);
    check(legs, 4'h0, "coast");
    check(device_mode, MODE_ACTIVE, "early sleep");
    wait_mode(MODE_SLEEP, SLP + 8);
  endtask : t_sleep

  // Main sequence: reset, then every scenario in turn.
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    sys_rst <= 1'b0;
    tick(4);
    check(device_mode, MODE_SLEEP, "power-up");
    check(legs, 4'h0, "power-up outputs");
    t_wake_decode();
    t_dead();
    t_deglitch();
    t_chop();
    t_abort();
    t_blank();
    t_overcurrent();
    t_thermal();
    t_lockout();
    t_sleep();
    tally_and_finish();
  end
endmodule : hbcs_ctrl_bench
